// ---- hw/j1939_pkg.sv ----
// Constants, register map and carrier types of the addressed message handler.
// Assumes a 50 MHz clock and 16-bit register words addressed by word index.
package j1939_pkg;
   localparam int          CLK_HZ       = 50_000_000;
   localparam int          TMO_STEP_MS  = 10;
   localparam int          TMO_STEP_CYC = TMO_STEP_MS * (CLK_HZ / 1000);
   localparam logic [7:0]  MAX_LEN      = 8'hfc;
   localparam logic [7:0]  MIN_LEN      = 8'h01;
   localparam logic [7:0]  SP_BYTES     = 8'h08;
   localparam logic [2:0]  PKT_LAST     = 3'h7;
   localparam logic [17:0] PGN_REQUEST  = 18'h0ea00;
   // Word offsets
   localparam logic [9:0]  OFS_TX_LEN    = 10'h000;
   localparam logic [9:0]  OFS_RSVD_ONE  = 10'h001;
   localparam logic [9:0]  OFS_TX_RES    = 10'h002;
   localparam logic [9:0]  OFS_TX_FLAGS  = 10'h003;
   localparam logic [9:0]  OFS_RSVD_FOUR = 10'h004;
   localparam logic [9:0]  OFS_RX_LEN    = 10'h005;
   localparam logic [9:0]  OFS_RX_RES    = 10'h006;
   localparam logic [9:0]  OFS_RX_FLAGS  = 10'h007;
   localparam logic [9:0]  OFS_CTRL      = 10'h008;
   localparam logic [9:0]  OFS_RX_MAX    = 10'h009;
   localparam logic [9:0]  OFS_TX_MAX    = 10'h00a;
   localparam logic [9:0]  OFS_RX_TMO    = 10'h00b;
   localparam logic [1:0]  PAGE_RX_DATA  = 2'h1;
   localparam logic [1:0]  PAGE_TX_DATA  = 2'h2;
   // Field positions
   localparam int          CTRL_SEND    = 0;
   localparam int          CTRL_REQ     = 1;
   localparam int          FLAG_BIT     = 0;
   // Reset values
   localparam logic [15:0] RST_WORD     = 16'h0000;
   localparam logic [15:0] RST_TMO      = 16'h0000;
   // Status codes
   localparam logic [15:0] TX_NORMAL    = 16'h0000;
   localparam logic [15:0] TX_MULTI     = 16'h0001;
   localparam logic [15:0] TX_LEN_ERR   = 16'h000a;
   localparam logic [15:0] TX_QUEUE_ERR = 16'h0014;
   localparam logic [15:0] TX_MP_ERR    = 16'h0064;
   localparam logic [15:0] TX_NO_LOCAL  = 16'h00c8;
   localparam logic [15:0] TX_NO_DEST   = 16'h00c9;
   localparam logic [15:0] RX_TIMEOUT   = 16'h000a;
   localparam logic [15:0] RX_LEN_ERR   = 16'h0064;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [9:0]  addr;
      logic [15:0] wdata;
   } reg_req_type;

   typedef struct packed {
      logic       valid;
      logic       last;
      logic [7:0] data;
   } rx_byte_type;

   typedef struct packed {
      logic       valid;
      logic       first;
      logic       pkt_end;
      logic       last;
      logic [7:0] data;
   } tx_byte_type;
endpackage : j1939_pkg

// ---- hw/j1939_addressed_message_handler.sv ----
// Scan-synchronised receive/transmit handler for one addressed peer application.
// Assumes a one-cycle end-of-scan pulse and synchronous network byte handshakes.
//
// How it works
// - Incoming bytes go to a buffer, copied to storage only after end-of-scan.
// - Copy done raises notify flag until the next end-of-scan pulse.
// - A newer message overwrites the buffer; only the latest is stored.
// - Maximum payload lengths are clamped to at most 252 bytes.
// - Receive timeout counts 10 ms steps from a 16-bit setting.
// - Timeout setting zero disables receive interval monitoring.
// - Storage spans max-length consecutive locations from its base.
// - Transmit sends transmit-length bytes from start of transmit storage.
// - Transmit length zero sends the configured maximum length.
// - Transmit length above maximum is refused with result 10.
// - Payloads over eight bytes go out as packets of eight bytes, the last packet holding the rest.
// - Each transmit outcome is recorded; software clears by writing zero.
// - Result 0 after single frame, 1 after completed multi-packet send.
// - Full transmit queue is refused with result 20.
// - Failed multi-packet send reports result 100.
// - Unconfirmed local address gives 200, unconfirmed destination 201.
// - Request-received flag sets on peer request, clears once sent.
// - Send trigger transmits after end-of-scan, then self-clears once sent; a refused send leaves it set.
// - Timeout elapsed with no new message writes receive status 10.
// - Oversize receive stores max length and receive status 100.
// - Request trigger sends request group 59904 at end-of-scan.
`timescale 1ns/1ns
module j1939_addressed_message_handler #(
   parameter int unsigned TMO_CYC = j1939_pkg::TMO_STEP_CYC
) (
   input  wire logic                   i_clk,
   input  wire logic                   i_rst_n,
   input  wire logic                   i_eos,
   input  wire j1939_pkg::reg_req_type i_reg,
   output logic [15:0]                 o_rd_data,
   input  wire j1939_pkg::rx_byte_type i_rx,
   output logic                        o_rx_ready,
   input  wire logic                   i_rx_req,
   input  wire logic                   i_local_addr_ok,
   input  wire logic                   i_dest_addr_ok,
   input  wire logic                   i_tx_queue_full,
   output j1939_pkg::tx_byte_type      o_tx,
   input  wire logic                   i_tx_ready,
   input  wire logic                   i_tx_done,
   input  wire logic                   i_tx_fail,
   output logic                        o_req_valid,
   output logic [17:0]                 o_req_pgn,
   output logic                        o_notify
);
   typedef enum logic [2:0] {ST_IDLE, ST_COPY, ST_CHECK, ST_SEND, ST_WAIT} state_type;

   state_type             state_r;
   state_type             state_nxt;
   logic [7:0]            rx_buf   [0:251];
   logic [7:0]            rx_store [0:251];
   logic [7:0]            tx_store [0:251];
   logic [15:0]           tx_len_r, tx_res_r, rx_res_r, rx_tmo_r;
   logic [7:0]            rx_max_r, tx_max_r, rx_len_r;
   logic                  send_trig_r, req_trig_r, req_flag_r, ovw_r;
   logic [7:0]            rx_wp_r, rx_hlen_r, cp_len_r, idx_r, len_r;
   logic                  rx_pending_r, rx_herr_r, cp_err_r, tx_go_r, multi_r;
   logic [31:0]           tick_r;
   logic [15:0]           step_r;
   logic                  tmo_hit;
   logic                  rx_take, rx_end, copy_done, tx_acc, send_done;
   logic                  wr_ctrl;
   logic [15:0]           tx_eff, tx_code;
   logic                  tx_ok;
   j1939_pkg::tx_byte_type tx_r;
   logic [7:0]            wclamp;

   assign rx_take   = i_rx.valid && o_rx_ready;
   assign rx_end    = rx_take && i_rx.last;
   assign copy_done = (state_r == ST_COPY) && (idx_r >= cp_len_r);
   assign tx_acc    = tx_r.valid && i_tx_ready;
   assign send_done = (state_r == ST_SEND) && (idx_r >= len_r) && (!tx_r.valid || i_tx_ready);
   assign wr_ctrl   = i_reg.wr && (i_reg.addr == j1939_pkg::OFS_CTRL);
   assign wclamp    = (i_reg.wdata > {8'h00, j1939_pkg::MAX_LEN}) ? j1939_pkg::MAX_LEN :
                      (i_reg.wdata[7:0] == 8'h00) ? j1939_pkg::MIN_LEN : i_reg.wdata[7:0];
   assign tx_eff    = (tx_len_r == 16'h0000) ? {8'h00, tx_max_r} : tx_len_r;

   always_comb
   begin
      tx_ok   = 1'b0;
      tx_code = j1939_pkg::TX_NORMAL;
      if (!i_local_addr_ok)
         tx_code = j1939_pkg::TX_NO_LOCAL;
      else if (!i_dest_addr_ok)
         tx_code = j1939_pkg::TX_NO_DEST;
      else if (tx_len_r > {8'h00, tx_max_r})
         tx_code = j1939_pkg::TX_LEN_ERR;
      else if (i_tx_queue_full)
         tx_code = j1939_pkg::TX_QUEUE_ERR;
      else
         tx_ok = 1'b1;
   end

   // Scan sequencer; a pulse seen while busy is not serviced, so work waits a scan
   always_comb
   begin
      state_nxt = state_r;
      unique case (state_r)
         ST_IDLE:
            if (i_eos)
               state_nxt = rx_pending_r ? ST_COPY :
                           (send_trig_r || req_flag_r) ? ST_CHECK : ST_IDLE;
         ST_COPY:
            if (copy_done)
               state_nxt = tx_go_r ? ST_CHECK : ST_IDLE;
         ST_CHECK:
            state_nxt = tx_ok ? ST_SEND : ST_IDLE;
         ST_SEND:
            if (send_done)
               state_nxt = ST_WAIT;
         ST_WAIT:
            if (i_tx_done)
               state_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         state_r    <= ST_IDLE;
         o_rx_ready <= 1'b0;
         tx_go_r    <= 1'b0;
         cp_len_r   <= 8'h00;
         cp_err_r   <= 1'b0;
      end
      else
      begin
         state_r    <= state_nxt;
         o_rx_ready <= (state_nxt != ST_COPY);
         if (state_r == ST_IDLE && i_eos)
         begin
            tx_go_r  <= send_trig_r || req_flag_r;
            cp_len_r <= rx_hlen_r;
            cp_err_r <= rx_herr_r;
         end
      end
   end

   // Receive buffer; the handler never stalls mid-message except during a copy
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         rx_wp_r      <= 8'h00;
         rx_hlen_r    <= 8'h00;
         rx_herr_r    <= 1'b0;
         rx_pending_r <= 1'b0;
         ovw_r        <= 1'b0;
      end
      else
      begin
         if (i_eos)
            ovw_r <= 1'b0;
         if (state_r == ST_IDLE && i_eos && rx_pending_r)
            rx_pending_r <= 1'b0;
         if (rx_take)
         begin
            if (rx_wp_r < rx_max_r)
               rx_buf[rx_wp_r] <= i_rx.data;
            rx_wp_r <= (rx_wp_r == 8'hff) ? rx_wp_r : rx_wp_r + 8'h01;
            if (i_rx.last)
            begin
               rx_wp_r      <= 8'h00;
               rx_pending_r <= 1'b1;
               rx_herr_r    <= (rx_wp_r >= rx_max_r);
               rx_hlen_r    <= (rx_wp_r >= rx_max_r) ? rx_max_r : rx_wp_r + 8'h01;
               if (rx_pending_r)
                  ovw_r <= 1'b1;
            end
         end
      end
   end

   // Copy, packet sender and index share one counter, never in use at once
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         idx_r   <= 8'h00;
         len_r   <= 8'h00;
         multi_r <= 1'b0;
         tx_r    <= '0;
      end
      else
      begin
         if (state_r == ST_IDLE || state_r == ST_CHECK)
            idx_r <= 8'h00;
         if (state_r == ST_CHECK)
         begin
            len_r   <= tx_eff[7:0];
            multi_r <= tx_eff > {8'h00, j1939_pkg::SP_BYTES};
         end
         if (state_r == ST_COPY && !copy_done)
         begin
            rx_store[idx_r] <= rx_buf[idx_r];
            idx_r           <= idx_r + 8'h01;
         end
         if (state_r == ST_SEND && (!tx_r.valid || i_tx_ready))
         begin
            if (idx_r < len_r)
            begin
               tx_r.valid   <= 1'b1;
               tx_r.data    <= tx_store[idx_r];
               tx_r.first   <= (idx_r[2:0] == 3'h0);
               tx_r.last    <= (idx_r == len_r - 8'h01);
               tx_r.pkt_end <= (idx_r[2:0] == j1939_pkg::PKT_LAST) ||
                               (idx_r == len_r - 8'h01);
               idx_r        <= idx_r + 8'h01;
            end
            else
               tx_r.valid <= 1'b0;
         end
      end
   end
   assign o_tx = tx_r;

   // Receive interval watchdog
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         tick_r <= 32'h0000_0000;
         step_r <= 16'h0000;
      end
      else if (rx_end)
      begin
         tick_r <= 32'h0000_0000;
         step_r <= 16'h0000;
      end
      else if (step_r != rx_tmo_r)
      begin
         tick_r <= (tick_r == 32'(TMO_CYC - 1)) ? 32'h0000_0000 : tick_r + 32'h1;
         if (tick_r == 32'(TMO_CYC - 1))
            step_r <= step_r + 16'h0001;
      end
   end
   assign tmo_hit = (rx_tmo_r != 16'h0000) && (step_r != rx_tmo_r) &&
                    (tick_r == 32'(TMO_CYC - 1)) && (step_r + 16'h0001 == rx_tmo_r) && !rx_end;

   // Software registers; hardware set always wins over a software clear
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         tx_len_r    <= j1939_pkg::RST_WORD;
         tx_res_r    <= j1939_pkg::RST_WORD;
         rx_res_r    <= j1939_pkg::RST_WORD;
         rx_len_r    <= 8'h00;
         rx_tmo_r    <= j1939_pkg::RST_TMO;
         rx_max_r    <= j1939_pkg::MAX_LEN;
         tx_max_r    <= j1939_pkg::MAX_LEN;
         send_trig_r <= 1'b0;
         req_trig_r  <= 1'b0;
         req_flag_r  <= 1'b0;
         o_notify    <= 1'b0;
         o_req_valid <= 1'b0;
         o_req_pgn   <= 18'h00000;
      end
      else
      begin
         o_req_valid <= 1'b0;
         if (i_reg.wr)
         begin
            unique case (i_reg.addr)
               j1939_pkg::OFS_TX_LEN: tx_len_r <= i_reg.wdata;
               j1939_pkg::OFS_RX_TMO: rx_tmo_r <= i_reg.wdata;
               j1939_pkg::OFS_RX_MAX: rx_max_r <= wclamp;
               j1939_pkg::OFS_TX_MAX: tx_max_r <= wclamp;
               j1939_pkg::OFS_TX_RES:
                  if (i_reg.wdata == 16'h0000)
                     tx_res_r <= 16'h0000;
               j1939_pkg::OFS_RX_RES:
                  if (i_reg.wdata == 16'h0000)
                     rx_res_r <= 16'h0000;
               default: ;
            endcase
         end
         if (wr_ctrl && i_reg.wdata[j1939_pkg::CTRL_SEND])
            send_trig_r <= 1'b1;
         else if (state_r == ST_WAIT && i_tx_done)
            send_trig_r <= 1'b0;
         if (i_rx_req)
            req_flag_r <= 1'b1;
         else if (state_r == ST_WAIT && i_tx_done && !i_tx_fail)
            req_flag_r <= 1'b0;
         if (i_eos && req_trig_r)
         begin
            o_req_valid <= 1'b1;
            o_req_pgn   <= j1939_pkg::PGN_REQUEST;
         end
         if (wr_ctrl && i_reg.wdata[j1939_pkg::CTRL_REQ])
            req_trig_r <= 1'b1;
         else if (i_eos)
            req_trig_r <= 1'b0;
         if (i_eos)
            o_notify <= 1'b0;
         if (copy_done)
         begin
            o_notify <= 1'b1;
            rx_len_r <= cp_len_r;
            if (cp_err_r)
               rx_res_r <= j1939_pkg::RX_LEN_ERR;
         end
         if (tmo_hit)
            rx_res_r <= j1939_pkg::RX_TIMEOUT;
         if (state_r == ST_CHECK && !tx_ok)
            tx_res_r <= tx_code;
         if (state_r == ST_WAIT && i_tx_done)
            tx_res_r <= !multi_r ? j1939_pkg::TX_NORMAL :
                        i_tx_fail ? j1939_pkg::TX_MP_ERR : j1939_pkg::TX_MULTI;
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_reg.wr && i_reg.addr[9:8] == j1939_pkg::PAGE_TX_DATA && i_reg.addr[7:0] < tx_max_r)
         tx_store[i_reg.addr[7:0]] <= i_reg.wdata[7:0];
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
         o_rd_data <= 16'h0000;
      else if (i_reg.rd)
      begin
         o_rd_data <= 16'h0000;
         if (i_reg.addr[9:8] == j1939_pkg::PAGE_RX_DATA && i_reg.addr[7:0] < j1939_pkg::MAX_LEN)
            o_rd_data <= {8'h00, rx_store[i_reg.addr[7:0]]};
         else if (i_reg.addr[9:8] == j1939_pkg::PAGE_TX_DATA &&
                  i_reg.addr[7:0] < j1939_pkg::MAX_LEN)
            o_rd_data <= {8'h00, tx_store[i_reg.addr[7:0]]};
         else
            unique case (i_reg.addr)
               j1939_pkg::OFS_TX_LEN:   o_rd_data <= tx_len_r;
               j1939_pkg::OFS_TX_RES:   o_rd_data <= tx_res_r;
               j1939_pkg::OFS_TX_FLAGS: o_rd_data <= {15'h0000, req_flag_r};
               j1939_pkg::OFS_RX_LEN:   o_rd_data <= {8'h00, rx_len_r};
               j1939_pkg::OFS_RX_RES:   o_rd_data <= rx_res_r;
               j1939_pkg::OFS_RX_FLAGS: o_rd_data <= {15'h0000, ovw_r};
               j1939_pkg::OFS_CTRL:     o_rd_data <= {14'h0000, req_trig_r, send_trig_r};
               j1939_pkg::OFS_RX_MAX:   o_rd_data <= {8'h00, rx_max_r};
               j1939_pkg::OFS_TX_MAX:   o_rd_data <= {8'h00, tx_max_r};
               j1939_pkg::OFS_RX_TMO:   o_rd_data <= rx_tmo_r;
               default:                 o_rd_data <= 16'h0000;
            endcase
      end
   end

   // Helper counter for the checks below
   logic [7:0] sent_r;
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n || state_r == ST_CHECK)
         sent_r <= 8'h00;
      else if (tx_acc)
         sent_r <= sent_r + 8'h01;
   end

   a_copy_after_eos: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      $rose(state_r == ST_COPY) |-> $past(i_eos)) else $error("copy without scan end");
   a_notify_one_scan: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      o_notify && i_eos |=> !o_notify) else $error("notify held past scan");
   a_max_len_cap: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      rx_max_r <= 8'hfc && tx_max_r <= 8'hfc) else $error("max length over 252");
   a_timeout_off: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      rx_tmo_r == 16'h0000 && $past(rx_tmo_r) == 16'h0000 && rx_res_r != 16'h000a
      |=> rx_res_r != 16'h000a) else $error("timeout while disabled");
   a_tx_byte_count: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      tx_acc && tx_r.last |-> sent_r == len_r - 8'h01) else $error("wrong byte count");
   a_packet_eight: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      tx_acc && tx_r.pkt_end && !tx_r.last |-> sent_r[2:0] == 3'h7)
      else $error("packet not eight bytes");
   a_result_multi: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      state_r == ST_WAIT && i_tx_done && !i_tx_fail && multi_r |=> tx_res_r == 16'h0001)
      else $error("multi result not 1");
   a_local_refused: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      state_r == ST_CHECK && !i_local_addr_ok |=> tx_res_r == 16'h00c8 && state_r == ST_IDLE)
      else $error("local address not refused");
   a_trigger_clear: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      state_r == ST_WAIT && i_tx_done && !wr_ctrl |=> !send_trig_r)
      else $error("trigger not cleared");
   a_request_pgn: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      i_eos && req_trig_r |=> o_req_valid && o_req_pgn == 18'h0ea00 ##1 !o_req_valid)
      else $error("request not sent");

   c_copy_done: cover property (@(posedge i_clk) disable iff (!i_rst_n) $rose(o_notify));
   c_multi_sent: cover property (@(posedge i_clk) disable iff (!i_rst_n)
      state_r == ST_WAIT && i_tx_done && multi_r);
   c_rx_timeout: cover property (@(posedge i_clk) disable iff (!i_rst_n) tmo_hit);
endmodule : j1939_addressed_message_handler

// ---- testbench/j1939_peer_model.sv ----
// Network-side peer model: sends addressed messages and takes transmit bytes.
// Assumes the handler's byte handshakes on the one shared clock.
`timescale 1ns/1ns
module j1939_peer_model (
   input  wire logic                   i_clk,
   input  wire logic                   i_rst_n,
   input  wire logic                   i_go,
   input  wire logic [7:0]             i_len,
   input  wire logic                   i_slow,
   input  wire logic                   i_fail,
   output j1939_pkg::rx_byte_type      o_rx,
   input  wire logic                   i_rx_ready,
   input  wire j1939_pkg::tx_byte_type i_tx,
   output logic                        o_tx_ready,
   output logic                        o_tx_done,
   output logic                        o_tx_fail,
   output logic [7:0]                  o_cnt,
   output logic [7:0]                  o_last,
   output logic                        o_bad,
   output logic [7:0]                  o_msgs
);
   logic [7:0] left_r;
   logic [7:0] pos_r;
   logic       stall_r;
   logic       take;
   // Slow mode accepts every other cycle so the sender must hold its byte
   assign o_tx_ready = !i_slow || stall_r;
   assign take       = i_tx.valid && o_tx_ready;
   always_ff @(posedge i_clk)
   begin
      stall_r   <= !stall_r;
      o_tx_done <= take && i_tx.last;
      o_tx_fail <= i_fail;
      if (!i_rst_n)
      begin
         o_rx   <= '0;
         stall_r <= 1'b0;
         left_r <= '0;
         pos_r  <= '0;
         o_cnt  <= '0;
         o_bad  <= 1'b0;
         o_msgs <= '0;
      end
      else
      begin
         if (i_go)
         begin
            left_r     <= i_len;
            o_rx.valid <= 1'b1;
            o_rx.data  <= {i_len[3:0], 4'h0};
            o_rx.last  <= (i_len == 8'h01);
         end
         else if (o_rx.valid && i_rx_ready)
         begin
            left_r     <= left_r - 8'h01;
            o_rx.valid <= (left_r != 8'h01);
            o_rx.data  <= o_rx.data + 8'h01;
            o_rx.last  <= (left_r == 8'h02);
         end
         else if (!o_rx.valid)
            o_rx.data <= ~o_rx.data; // Idle data never repeats the last byte
         if (take)
         begin
            o_cnt  <= pos_r + 8'h01;
            o_last <= i_tx.data;
            pos_r  <= i_tx.last ? 8'h00 : pos_r + 8'h01;
            o_msgs <= o_msgs + {7'h00, i_tx.last};
            if (i_tx.first != (pos_r[2:0] == 3'h0) ||
                i_tx.pkt_end != (pos_r[2:0] == 3'h7 || i_tx.last))
               o_bad <= 1'b1;
         end
      end
   end
endmodule : j1939_peer_model

// ---- testbench/j1939_addressed_message_handler_tb_top.sv ----
// Self-checking bench: register tasks, scan pulses, peer traffic.
// Assumes the handler's register map and a peer model on the network side.
`timescale 1ns/1ns
module j1939_addressed_message_handler_tb_top;
   logic                   i_clk = 1'b0;
   logic                   rst_n = 1'b0;
   logic                   eos = 1'b0;
   j1939_pkg::reg_req_type rq = '0;
   logic [15:0]            rd_data;
   j1939_pkg::rx_byte_type rx;
   j1939_pkg::tx_byte_type tx;
   logic                   rx_ready, rx_req = 1'b0, lok = 1'b1, dok = 1'b1, qf = 1'b0;
   logic                   tx_ready, done, fail, req_valid, notify;
   logic [17:0]            req_pgn;
   logic                   go = 1'b0, slow = 1'b0, mfail = 1'b0, bad;
   logic [7:0]             len = '0, cnt, last, msgs;
   int                     fails = 0, checked = 0, cyc = 0, n;
   logic [15:0]            exp_res [4] = '{16'h000a, 16'h0014, 16'h00c8, 16'h00c9};

   initial forever #10 i_clk = ~i_clk;

   j1939_addressed_message_handler #(.TMO_CYC(4)) DUT (
      .i_clk(i_clk), .i_rst_n(rst_n), .i_eos(eos), .i_reg(rq), .o_rd_data(rd_data),
      .i_rx(rx), .o_rx_ready(rx_ready), .i_rx_req(rx_req), .i_local_addr_ok(lok),
      .i_dest_addr_ok(dok), .i_tx_queue_full(qf), .o_tx(tx), .i_tx_ready(tx_ready),
      .i_tx_done(done), .i_tx_fail(fail), .o_req_valid(req_valid), .o_req_pgn(req_pgn),
      .o_notify(notify));

   j1939_peer_model peer (
      .i_clk(i_clk), .i_rst_n(rst_n), .i_go(go), .i_len(len), .i_slow(slow),
      .i_fail(mfail), .o_rx(rx), .i_rx_ready(rx_ready), .i_tx(tx), .o_tx_ready(tx_ready),
      .o_tx_done(done), .o_tx_fail(fail), .o_cnt(cnt), .o_last(last), .o_bad(bad),
      .o_msgs(msgs));

   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : end_of_test

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         fails++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [9:0] a, input logic [15:0] d);
      @(posedge i_clk);
      rq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge i_clk);
      rq <= '0;
   endtask : wr

   task automatic rd(input logic [9:0] a, input logic [15:0] exp);
      @(posedge i_clk);
      rq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
      @(posedge i_clk);
      rq <= '0;
      #1;
      chk(rd_data, exp);
   endtask : rd

   task automatic scan;
      @(posedge i_clk);
      eos <= 1'b1;
      @(posedge i_clk);
      eos <= 1'b0;
   endtask : scan

   task automatic send(input logic [7:0] l);
      @(posedge i_clk);
      go  <= 1'b1;
      len <= l;
      @(posedge i_clk);
      go <= 1'b0;
      #1;
      for (int i = 0; i < 300 && rx.valid !== 1'b0; i++)
      begin
         @(posedge i_clk);
         #1;
      end
   endtask : send

   // A whole scan may pass before the handler starts, so the wait is generous
   task automatic xmit(input logic trig);
      logic [7:0] m;
      m = msgs;
      if (trig)
         wr(j1939_pkg::OFS_CTRL, 16'h0001);
      scan();
      for (int i = 0; i < 600 && msgs === m; i++)
         @(posedge i_clk);
      repeat (4) @(posedge i_clk);
   endtask : xmit

   always @(posedge i_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         fails++;
         end_of_test();
      end
   end

   initial
   begin
      repeat (3) @(posedge i_clk);
      rst_n <= 1'b1;
      rd(j1939_pkg::OFS_TX_MAX, 16'h00fc);
      rd(j1939_pkg::OFS_RSVD_ONE, 16'h0000);
      rd(j1939_pkg::OFS_RSVD_FOUR, 16'h0000);
      rd(10'h3ff, 16'h0000);
      rd(j1939_pkg::OFS_TX_RES, 16'h0000);
      wr(j1939_pkg::OFS_TX_MAX, 16'h0123);
      rd(j1939_pkg::OFS_TX_MAX, 16'h00fc);
      $display("test registers done");
      wr(j1939_pkg::OFS_RX_MAX, 16'h0004);
      send(8'h02);
      send(8'h03);
      chk(notify, 1'b0);
      rd(j1939_pkg::OFS_RX_FLAGS, 16'h0001);
      scan();
      repeat (20) @(posedge i_clk);
      chk(notify, 1'b1);
      rd(j1939_pkg::OFS_RX_LEN, 16'h0003);
      for (int i = 0; i < 3; i++)
         rd({j1939_pkg::PAGE_RX_DATA, 8'(i)}, 16'h0030 + 16'(i));
      scan();
      repeat (2) @(posedge i_clk);
      chk(notify, 1'b0);
      send(8'h06);
      scan();
      repeat (20) @(posedge i_clk);
      rd(j1939_pkg::OFS_RX_LEN, 16'h0004);
      rd(j1939_pkg::OFS_RX_RES, 16'h0064);
      wr(j1939_pkg::OFS_RX_RES, 16'h0000);
      wr(j1939_pkg::OFS_RX_TMO, 16'h000a);
      send(8'h01);
      scan();
      repeat (10) @(posedge i_clk);
      rd(j1939_pkg::OFS_RX_RES, 16'h0000);
      repeat (40) @(posedge i_clk);
      rd(j1939_pkg::OFS_RX_RES, 16'h000a);
      wr(j1939_pkg::OFS_RX_TMO, 16'h0000);
      send(8'h01);
      scan();
      repeat (10) @(posedge i_clk);
      wr(j1939_pkg::OFS_RX_RES, 16'h0000);
      repeat (60) @(posedge i_clk);
      rd(j1939_pkg::OFS_RX_RES, 16'h0000);
      $display("test receive done");
      for (int i = 0; i < 12; i++)
         wr({j1939_pkg::PAGE_TX_DATA, 8'(i)}, 16'h0040 + 16'(i));
      slow <= 1'b1;
      wr(j1939_pkg::OFS_TX_LEN, 16'h000c);
      xmit(1'b1);
      chk({cnt, last, 7'h00, bad}, 32'h000c4b00);
      rd(j1939_pkg::OFS_TX_RES, 16'h0001);
      rd(j1939_pkg::OFS_CTRL, 16'h0000);
      slow <= 1'b0;
      wr(j1939_pkg::OFS_TX_LEN, 16'h0003);
      xmit(1'b1);
      chk({cnt, last}, 16'h0342);
      rd(j1939_pkg::OFS_TX_RES, 16'h0000);
      mfail <= 1'b1;
      wr(j1939_pkg::OFS_TX_LEN, 16'h000c);
      xmit(1'b1);
      rd(j1939_pkg::OFS_TX_RES, 16'h0064);
      mfail <= 1'b0;
      wr(j1939_pkg::OFS_TX_RES, 16'h0000);
      rd(j1939_pkg::OFS_TX_RES, 16'h0000);
      wr(j1939_pkg::OFS_TX_MAX, 16'h000a);
      wr(j1939_pkg::OFS_TX_LEN, 16'h0000);
      xmit(1'b1);
      chk({cnt, last}, 16'h0a49);
      for (int k = 0; k < 4; k++)
      begin
         lok <= (k != 2);
         dok <= (k != 3);
         qf  <= (k == 1);
         n = msgs;
         wr(j1939_pkg::OFS_TX_LEN, (k == 0) ? 16'h000b : 16'h0003);
         wr(j1939_pkg::OFS_CTRL, 16'h0001);
         scan();
         repeat (6) @(posedge i_clk);
         rd(j1939_pkg::OFS_TX_RES, exp_res[k]);
         chk(msgs, n[7:0]);
      end
      lok <= 1'b1;
      dok <= 1'b1;
      qf  <= 1'b0;
      @(posedge i_clk);
      rx_req <= 1'b1;
      @(posedge i_clk);
      rx_req <= 1'b0;
      rd(j1939_pkg::OFS_TX_FLAGS, 16'h0001);
      xmit(1'b0);
      chk(cnt, 8'h03);
      rd(j1939_pkg::OFS_TX_FLAGS, 16'h0000);
      wr(j1939_pkg::OFS_CTRL, 16'h0002);
      scan();
      n = 0;
      repeat (4)
      begin
         #1;
         if (req_valid === 1'b1)
         begin
            n++;
            chk(req_pgn, j1939_pkg::PGN_REQUEST);
         end
         @(posedge i_clk);
      end
      chk(n, 1);
      rd(j1939_pkg::OFS_CTRL, 16'h0000);
      $display("test transmit done");
      end_of_test();
   end
endmodule : j1939_addressed_message_handler_tb_top
